/* hdl/cad_pkg.sv */
// Purpose: shared constants and types for the compressed alu op decoder
// Assumes: 16-bit opcodes, 32-bit datapath, sixteen architectural registers
// Notes:   field positions follow the usual compressed encoding
package cad_pkg;
  // group tags in the top opcode bits
  localparam logic [4:0] CAD_F2_TAG      = 5'h03;  // [15:11] add/subtract
  localparam logic [2:0] CAD_F3_TAG      = 3'h1;   // [15:13] 8-bit immediate
  localparam logic [5:0] CAD_F4_TAG      = 6'h10;  // [15:10] two-register alu
  localparam logic [5:0] CAD_F5_TAG      = 6'h11;  // [15:10] high register / branch
  // field positions (lsb of each field)
  localparam int         CAD_RD_LSB      = 0;
  localparam int         CAD_RS_LSB      = 3;
  localparam int         CAD_RN_LSB      = 6;
  localparam int         CAD_F2_IMM_BIT  = 10;
  localparam int         CAD_F2_OP_BIT   = 9;
  localparam int         CAD_F3_OP_LSB   = 11;
  localparam int         CAD_F3_RD_LSB   = 8;
  localparam int         CAD_F4_OP_LSB   = 6;
  localparam int         CAD_F5_OP_LSB   = 8;
  localparam int         CAD_F5_DH_BIT   = 7;
  localparam int         CAD_F5_SH_BIT   = 6;
  // 8-bit immediate group codes
  localparam logic [1:0] CAD_I8_MOV      = 2'h0;
  localparam logic [1:0] CAD_I8_CMP      = 2'h1;
  localparam logic [1:0] CAD_I8_ADD      = 2'h2;
  localparam logic [1:0] CAD_I8_SUB      = 2'h3;
  // two-register alu codes
  localparam logic [3:0] CAD_OP_AND      = 4'h0;
  localparam logic [3:0] CAD_OP_XOR      = 4'h1;
  localparam logic [3:0] CAD_OP_LSL      = 4'h2;
  localparam logic [3:0] CAD_OP_LSR      = 4'h3;
  localparam logic [3:0] CAD_OP_ASHR     = 4'h4;
  localparam logic [3:0] CAD_OP_ADC      = 4'h5;
  localparam logic [3:0] CAD_OP_SUBC     = 4'h6;
  localparam logic [3:0] CAD_OP_ROTR     = 4'h7;
  localparam logic [3:0] CAD_OP_ANDT     = 4'h8;
  localparam logic [3:0] CAD_OP_NEGATE   = 4'h9;
  localparam logic [3:0] CAD_OP_CMP      = 4'hA;
  localparam logic [3:0] CAD_OP_CMPADD   = 4'hB;
  localparam logic [3:0] CAD_OP_OR       = 4'hC;
  localparam logic [3:0] CAD_OP_MULT     = 4'hD;
  localparam logic [3:0] CAD_OP_ANDN     = 4'hE;
  localparam logic [3:0] CAD_OP_NOT      = 4'hF;
  // high register group codes
  localparam logic [1:0] CAD_HI_ADD      = 2'h0;
  localparam logic [1:0] CAD_HI_CMP      = 2'h1;
  localparam logic [1:0] CAD_HI_MOV      = 2'h2;
  localparam logic [1:0] CAD_HI_BRX      = 2'h3;
  // cycle counts of the expanded 32-bit forms
  localparam logic [2:0] CAD_CYC_DATA    = 3'h1;
  localparam logic [2:0] CAD_CYC_SHREG   = 3'h2;
  localparam logic [2:0] CAD_CYC_BRANCH  = 3'h3;
  localparam logic [2:0] CAD_CYC_MULT    = 3'h1;   // plus one per multiplier byte step
  // misc values
  localparam logic [3:0]  CAD_PC_REG     = 4'hF;
  localparam logic [31:0] CAD_PC_READ_OFS = 32'h0000_0004;
  localparam logic        CAD_RST_CSTATE = 1'b1;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cad_flags_t;

  typedef struct packed {
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic        flag_en;
    cad_flags_t  flags;
    logic        pc_load;
    logic [31:0] pc_tgt;
    logic        cstate;
  } cad_res_t;

  typedef enum logic {CAD_IDLE, CAD_WAIT} cad_state_t;
endpackage : cad_pkg

/* hdl/cad_decoder.sv */
// Purpose: decode and execute four groups of compressed alu instructions
// Assumes: opcode and its address arrive together with instr_valid
// Notes:   holds its own register copy; pc lives in fetch, loaded via pc_load_ff
//
// Functional notes
// - cycles equal the expanded 32-bit form
// - op bit: 0 adds, 1 subtracts
// - immediate bit picks register or imm3
// - groups two to four update flags
// - imm8 codes: 00 move, 01 compare
// - imm8 codes: 10 add, 11 subtract
// - add and subtract with carry flag
// - test and compares touch flags only
// - negate stores zero minus source
// - multiply stores product, sets flags
// - high bits reach registers 8 to 15
// - high group 00 add, 01 compare
// - only high compare changes flags
// - high code 10 moves across banks
// - branch exchange loads pc from register
// - target bit 0 selects new state
// - r15 reads as address plus 4
`timescale 1ns/1ns
module cad_decoder
  import cad_pkg::*;
(
  input  wire logic        mclk,         // core clock
  input  wire logic        rst,          // synchronous reset
  input  wire logic        instr_valid,  // opcode offered
  input  wire logic [15:0] instr,        // compressed opcode
  input  wire logic [31:0] instr_addr,   // address of the opcode
  output logic             ready_ff,     // opcode taken when high
  output logic             wr_en_ff,     // register write pulse
  output logic [3:0]       wr_addr_ff,   // register written
  output logic [31:0]      wr_data_ff,   // value written
  output cad_flags_t       flags_ff,     // processor_status_flags
  output logic             pc_load_ff,   // pc load pulse
  output logic [31:0]      pc_tgt_ff,    // new pc, bit 0 clear
  output logic             cstate_ff     // 1 in compressed state
);
  typedef struct packed {
    logic [31:0] sum;
    logic        c;
    logic        v;
  } cad_sum_t;

  logic [31:0] regs_ff [16];   // register copy, entry 15 unused
  logic [31:0] nxt_regs [16];
  cad_state_t  state_ff, nxt_state;
  logic [2:0]  cnt_ff, nxt_cnt;
  cad_res_t    pend_ff, nxt_pend;  // result waiting for its last cycle
  cad_res_t    ex;                 // result of the offered opcode
  logic [2:0]  ex_cyc;             // cycles the offered opcode takes
  cad_flags_t  nxt_flags;
  logic        nxt_ready, nxt_wr_en, nxt_pc_load, nxt_cstate;
  logic [3:0]  nxt_wr_addr;
  logic [31:0] nxt_wr_data, nxt_pc_tgt;
  logic        acc;              // opcode accepted this cycle

  assign acc = instr_valid && ready_ff && (state_ff == CAD_IDLE);

  // adder shared by the add, subtract and compare forms except the high register add
  function automatic cad_sum_t addc(input logic [31:0] a, input logic [31:0] b,
                                    input logic cin);
    cad_sum_t   r;
    logic [32:0] t;
    t = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
    r.sum = t[31:0];
    r.c = t[32];
    r.v = (a[31] == b[31]) && (t[31] != a[31]);
    return r;
  endfunction : addc

  // register read; r15 gives the pipelined pc view
  function automatic logic [31:0] rd_reg(input logic [3:0] idx,
                                         input logic [31:0] pc);
    logic [31:0] p;
    p = pc + CAD_PC_READ_OFS;
    if (idx == CAD_PC_REG) return {p[31:1], 1'b0};
    return regs_ff[idx];
  endfunction : rd_reg

  // decode and execute the offered opcode
  always_comb begin : decode
    logic [31:0] a, b, w, sh;
    logic [3:0]  dst;
    logic [7:0]  amt;
    logic        wen, fen, csh;
    cad_sum_t    s;
    a = '0;
    b = '0;
    w = '0;
    sh = '0;
    dst = '0;
    amt = '0;
    wen = 1'b0;
    fen = 1'b0;
    csh = flags_ff.c;
    s = '0;
    ex = '0;
    ex.flags = flags_ff;
    ex.cstate = cstate_ff;
    ex_cyc = CAD_CYC_DATA;
    if (instr[15:11] == CAD_F2_TAG) begin
      a = rd_reg({1'b0, instr[CAD_RS_LSB +: 3]}, instr_addr);
      b = instr[CAD_F2_IMM_BIT] ? {29'h0, instr[CAD_RN_LSB +: 3]}
                                : rd_reg({1'b0, instr[CAD_RN_LSB +: 3]}, instr_addr);
      s = instr[CAD_F2_OP_BIT] ? addc(a, ~b, 1'b1) : addc(a, b, 1'b0);
      dst = {1'b0, instr[CAD_RD_LSB +: 3]};
      w = s.sum;
      wen = 1'b1;
      fen = 1'b1;
    end else if (instr[15:13] == CAD_F3_TAG) begin
      dst = {1'b0, instr[CAD_F3_RD_LSB +: 3]};
      a = rd_reg(dst, instr_addr);
      b = {24'h0, instr[7:0]};
      fen = 1'b1;
      case (instr[CAD_F3_OP_LSB +: 2])
        CAD_I8_MOV: begin
          w = b;
          s = '{sum: b, c: flags_ff.c, v: flags_ff.v};
          wen = 1'b1;
        end
        CAD_I8_CMP: s = addc(a, ~b, 1'b1);
        CAD_I8_ADD: begin
          s = addc(a, b, 1'b0);
          wen = 1'b1;
        end
        default: begin
          s = addc(a, ~b, 1'b1);
          wen = 1'b1;
        end
      endcase
      w = s.sum;
    end else if (instr[15:10] == CAD_F4_TAG) begin
      dst = {1'b0, instr[CAD_RD_LSB +: 3]};
      a = rd_reg(dst, instr_addr);
      b = rd_reg({1'b0, instr[CAD_RS_LSB +: 3]}, instr_addr);
      amt = b[7:0];
      fen = 1'b1;
      wen = 1'b1;
      case (instr[CAD_F4_OP_LSB +: 4])
        CAD_OP_AND: sh = a & b;
        CAD_OP_XOR: sh = a ^ b;
        CAD_OP_OR: sh = a | b;
        CAD_OP_ANDN: sh = a & ~b;
        CAD_OP_NOT: sh = ~b;
        // register shifts, carry is the last bit out
        CAD_OP_LSL: begin
          if (amt != 8'h00) {csh, sh} = {1'b0, a} << amt;
          else sh = a;
          ex_cyc = CAD_CYC_SHREG;
        end
        CAD_OP_LSR: begin
          if (amt != 8'h00) {sh, csh} = {a, 1'b0} >> amt;
          else sh = a;
          ex_cyc = CAD_CYC_SHREG;
        end
        CAD_OP_ASHR: begin
          if (amt != 8'h00) {sh, csh} = $signed({a, 1'b0}) >>> amt;
          else sh = a;
          ex_cyc = CAD_CYC_SHREG;
        end
        CAD_OP_ROTR: begin
          sh = (a >> amt[4:0]) | (a << (6'h20 - {1'b0, amt[4:0]}));
          if (amt != 8'h00) csh = sh[31];
          ex_cyc = CAD_CYC_SHREG;
        end
        CAD_OP_ADC: s = addc(a, b, flags_ff.c);
        CAD_OP_SUBC: s = addc(a, ~b, flags_ff.c);
        CAD_OP_NEGATE: s = addc(32'h0000_0000, ~b, 1'b1);
        CAD_OP_ANDT: begin
          sh = a & b;
          wen = 1'b0;
        end
        CAD_OP_CMP: begin
          s = addc(a, ~b, 1'b1);
          wen = 1'b0;
        end
        CAD_OP_CMPADD: begin
          s = addc(a, b, 1'b0);
          wen = 1'b0;
        end
        // multiply, early exit on the multiplier in dst
        default: begin
          sh = a * b;
          if (a[31:8] == 24'h0 || a[31:8] == 24'hFF_FFFF) ex_cyc = CAD_CYC_MULT + 3'h1;
          else if (a[31:16] == 16'h0 || a[31:16] == 16'hFFFF) ex_cyc = CAD_CYC_MULT + 3'h2;
          else if (a[31:24] == 8'h0 || a[31:24] == 8'hFF) ex_cyc = CAD_CYC_MULT + 3'h3;
          else ex_cyc = CAD_CYC_MULT + 3'h4;
        end
      endcase
      // arithmetic forms take adder flags, others keep v and take shifter carry
      if (instr[CAD_F4_OP_LSB +: 4] inside {CAD_OP_ADC, CAD_OP_SUBC, CAD_OP_NEGATE,
                                             CAD_OP_CMP, CAD_OP_CMPADD}) begin
        w = s.sum;
      end else begin
        w = sh;
        s = '{sum: sh, c: csh, v: flags_ff.v};
      end
    end else if (instr[15:10] == CAD_F5_TAG) begin
      dst = {instr[CAD_F5_DH_BIT], instr[CAD_RD_LSB +: 3]};
      a = rd_reg(dst, instr_addr);
      b = rd_reg({instr[CAD_F5_SH_BIT], instr[CAD_RS_LSB +: 3]}, instr_addr);
      // code 10 move, code 11 branch
      case (instr[CAD_F5_OP_LSB +: 2])
        CAD_HI_ADD: begin
          w = a + b;
          wen = 1'b1;
        end
        // compare is the only flag writer here
        CAD_HI_CMP: begin
          s = addc(a, ~b, 1'b1);
          fen = 1'b1;
        end
        CAD_HI_MOV: begin
          w = b;
          wen = 1'b1;
        end
        // branch exchange, dest high bit is ignored
        default: begin
          ex.pc_load = 1'b1;
          ex.pc_tgt = {b[31:1], 1'b0};
          ex.cstate = b[0];
          ex_cyc = CAD_CYC_BRANCH;
        end
      endcase
    end
    if (fen) begin
      ex.flag_en = 1'b1;
      ex.flags = '{n: s.sum[31], z: (s.sum == 32'h0000_0000), c: s.c, v: s.v};
    end
    // writes to r15 become a pc load and refill like a branch
    if (wen && dst == CAD_PC_REG) begin
      ex.pc_load = 1'b1;
      ex.pc_tgt = {w[31:1], 1'b0};
      ex_cyc = CAD_CYC_BRANCH;
    end else if (wen) begin
      ex.wr_en = 1'b1;
      ex.wr_addr = dst;
      ex.wr_data = w;
    end
  end

  // sequencing: hold the result until its last cycle, then commit
  always_comb begin : next_state
    cad_res_t cres;
    logic     commit;
    cres = pend_ff;
    commit = 1'b0;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pend = pend_ff;
    nxt_ready = ready_ff;
    nxt_regs = regs_ff;
    nxt_flags = flags_ff;
    nxt_cstate = cstate_ff;
    nxt_wr_en = 1'b0;
    nxt_pc_load = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_pc_tgt = pc_tgt_ff;
    case (state_ff)
      CAD_IDLE: begin
        if (acc && ex_cyc == CAD_CYC_DATA) begin
          commit = 1'b1;
          cres = ex;
        end else if (acc) begin
          nxt_pend = ex;
          nxt_cnt = ex_cyc - 3'h1;
          nxt_state = CAD_WAIT;
          nxt_ready = 1'b0;
        end
      end
      CAD_WAIT: begin
        if (cnt_ff == 3'h1) begin
          commit = 1'b1;
          nxt_state = CAD_IDLE;
          nxt_ready = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
      default: begin
        nxt_state = CAD_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
    if (commit) begin
      nxt_wr_en = cres.wr_en;
      nxt_pc_load = cres.pc_load;
      nxt_cstate = cres.cstate;
      if (cres.wr_en) begin
        nxt_regs[cres.wr_addr] = cres.wr_data;
        nxt_wr_addr = cres.wr_addr;
        nxt_wr_data = cres.wr_data;
      end
      if (cres.flag_en) nxt_flags = cres.flags;
      if (cres.pc_load) nxt_pc_tgt = cres.pc_tgt;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin : regs
    if (rst) begin
      state_ff <= CAD_IDLE;
      cnt_ff <= '0;
      pend_ff <= '0;
      ready_ff <= 1'b1;
      regs_ff <= '{default: 32'h0000_0000};
      flags_ff <= '0;
      cstate_ff <= CAD_RST_CSTATE;
      wr_en_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      pc_load_ff <= 1'b0;
      pc_tgt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pend_ff <= nxt_pend;
      ready_ff <= nxt_ready;
      regs_ff <= nxt_regs;
      flags_ff <= nxt_flags;
      cstate_ff <= nxt_cstate;
      wr_en_ff <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      pc_load_ff <= nxt_pc_load;
      pc_tgt_ff <= nxt_pc_tgt;
    end
  end

  // checks on the committed results
  logic        is_f2, is_f3, is_f4, is_f5;
  logic [31:0] chk_rs, chk_rd3;
  assign is_f2 = acc && instr[15:11] == CAD_F2_TAG;
  assign is_f3 = acc && instr[15:13] == CAD_F3_TAG;
  assign is_f4 = acc && instr[15:10] == CAD_F4_TAG;
  assign is_f5 = acc && instr[15:10] == CAD_F5_TAG;
  assign chk_rs = regs_ff[{1'b0, instr[CAD_RS_LSB +: 3]}];
  assign chk_rd3 = regs_ff[{1'b0, instr[CAD_F3_RD_LSB +: 3]}];

  sequence s_branch_done;
    !ready_ff [*2] ##1 (ready_ff && pc_load_ff);
  endsequence
  property p_brx_cycles;
    @(posedge mclk) disable iff (rst)
    (is_f5 && instr[9:8] == CAD_HI_BRX) |-> ##1 s_branch_done;
  endproperty
  a_brx_cycles: assert property (p_brx_cycles) else $error("branch timing wrong");
  property p_brx_state;
    @(posedge mclk) disable iff (rst)
    (is_f5 && instr[9:8] == CAD_HI_BRX && instr[CAD_F5_SH_BIT] == 1'b0)
      |-> ##3 cstate_ff == $past(chk_rs[0], 3);
  endproperty
  a_brx_state: assert property (p_brx_state) else $error("state bit wrong");
  property p_add_imm3;
    @(posedge mclk) disable iff (rst)
    (is_f2 && instr[10:9] == 2'h2)
      |=> wr_en_ff && wr_data_ff == $past(chk_rs) + {29'h0, $past(instr[8:6])};
  endproperty
  a_add_imm3: assert property (p_add_imm3) else $error("add imm3 wrong");
  property p_cmp_imm8;
    @(posedge mclk) disable iff (rst)
    (is_f3 && instr[12:11] == CAD_I8_CMP)
      |=> !wr_en_ff && flags_ff.z == ($past(chk_rd3) == {24'h0, $past(instr[7:0])});
  endproperty
  a_cmp_imm8: assert property (p_cmp_imm8) else $error("compare imm8 wrong");
  property p_sub_imm8;
    @(posedge mclk) disable iff (rst)
    (is_f3 && instr[12:11] == CAD_I8_SUB)
      |=> wr_data_ff == $past(chk_rd3) - {24'h0, $past(instr[7:0])};
  endproperty
  a_sub_imm8: assert property (p_sub_imm8) else $error("sub imm8 wrong");
  property p_shift_cycles;
    @(posedge mclk) disable iff (rst)
    (is_f4 && instr[9:6] == CAD_OP_LSL) |=> !ready_ff ##1 (ready_ff && wr_en_ff);
  endproperty
  a_shift_cycles: assert property (p_shift_cycles) else $error("shift timing wrong");
  property p_negate;
    @(posedge mclk) disable iff (rst)
    (is_f4 && instr[9:6] == CAD_OP_NEGATE) |=> wr_data_ff == 32'h0000_0000 - $past(chk_rs);
  endproperty
  a_negate: assert property (p_negate) else $error("negate wrong");
  property p_andt_nowrite;
    @(posedge mclk) disable iff (rst)
    (is_f4 && instr[9:6] == CAD_OP_ANDT) |=> !wr_en_ff && ready_ff;
  endproperty
  a_andt_nowrite: assert property (p_andt_nowrite) else $error("test wrote register");
  property p_mult_done;
    @(posedge mclk) disable iff (rst)
    (is_f4 && instr[9:6] == CAD_OP_MULT) |-> ##[2:5] (wr_en_ff && ready_ff);
  endproperty
  a_mult_done: assert property (p_mult_done) else $error("multiply timing wrong");
  property p_hi_add_flags;
    @(posedge mclk) disable iff (rst)
    (is_f5 && instr[9:8] == CAD_HI_ADD) |=> flags_ff == $past(flags_ff);
  endproperty
  a_hi_add_flags: assert property (p_hi_add_flags) else $error("high add changed flags");
  property p_pc_read;
    @(posedge mclk) disable iff (rst)
    (is_f5 && instr[9:6] == 4'hB && instr[5:3] == 3'h7)
      |=> wr_data_ff == {$past(instr_addr[31:1]) + 31'h2, 1'b0};
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("pc read view wrong");
endmodule : cad_decoder

/* testbench/cad_fetch_model.sv */
// Purpose: fetch stage model offering compressed opcodes to the decoder
// Assumes: one opcode in flight, held until the decoder takes it
// Notes:   released lines flip to their inverse so a stale value never matches
`timescale 1ns/1ns
module cad_fetch_model
  import cad_pkg::*;
(
  input  wire logic        mclk,         // core clock
  input  wire logic        ready_ff,     // decoder takes when high
  output logic             instr_valid,  // opcode offered
  output logic [15:0]      instr,        // opcode lines
  output logic [31:0]      instr_addr    // address of the opcode
);
  // idle from time zero, nothing offered
  initial begin
    instr_valid = 1'b0;
    instr       = 16'hFFFF;
    instr_addr  = 32'h0;
  end

  // offer after a falling edge, hold until a rising edge samples ready high
  task automatic send(input logic [15:0] op, input logic [31:0] addr);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr       = op;
    instr_addr  = addr;
    do @(posedge mclk); while (ready_ff !== 1'b1);
  endtask : send

  // release: lines carry the inverse, not the last opcode
  task automatic drop();
    instr_valid = 1'b0;
    instr       = ~instr;
    instr_addr  = ~instr_addr;
  endtask : drop
endmodule : cad_fetch_model

/* testbench/cad_decoder_bench.sv */
// Purpose: self-checking bench for the compressed alu op decoder
// Assumes: bench keeps its own register and flag model of the core
// Notes:   random opcodes from a fixed seed plus hand-picked corners
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cad_decoder_bench
  import cad_pkg::*;
;
  logic        mclk = 1'b0;            // core clock
  logic        rst = 1'b1;             // synchronous reset
  logic        instr_valid, ready_ff, wr_en_ff, pc_load_ff, cstate_ff;
  logic [15:0] instr, op;              // opcode lines, scratch opcode
  logic [31:0] instr_addr, wr_data_ff, pc_tgt_ff, pc_addr, pt, ev;
  logic [3:0]  wr_addr_ff, ea;         // written index, expected index
  cad_flags_t  flags_ff, fl;           // design flags, model flags
  logic [31:0] rf [16];                // model registers, 15 is the pc read
  logic        th, ew, ep;             // expected state, write, pc load
  int          en, i;                  // expected cycles, loop index
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  integer      seed;
  logic [3:0]  shk [4] = '{CAD_OP_LSL, CAD_OP_LSR, CAD_OP_ASHR, CAD_OP_ROTR};

  cad_decoder cad_decoder_inst (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_addr(instr_addr), .ready_ff(ready_ff), .wr_en_ff(wr_en_ff),
    .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff), .flags_ff(flags_ff),
    .pc_load_ff(pc_load_ff), .pc_tgt_ff(pc_tgt_ff), .cstate_ff(cstate_ff));
  cad_fetch_model cad_fetch_model_inst (.mclk(mclk), .ready_ff(ready_ff),
    .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr));

  // 100 MHz clock
  always #5 mclk = ~mclk;
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin errors++; results(); end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // flags and sum of a + b + ci as {n, z, c, v, sum}
  function automatic logic [35:0] addc(input logic [31:0] a, b, input logic ci);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    return {s[31], s[31:0] == 32'h0, s[32], a[31] == b[31] && s[31] != a[31], s[31:0]};
  endfunction : addc

  function automatic int mult_cycles(input logic [31:0] m);
    if (&m[31:8] || m[31:8] == 24'h0) return 2;
    if (&m[31:16] || m[31:16] == 16'h0) return 3;
    if (&m[31:24] || m[31:24] == 8'h0) return 4;
    return 5;
  endfunction : mult_cycles

  // model one opcode: expectations and new model state
  task automatic exec(input logic [15:0] o);
    logic [31:0] d, s, r;
    logic [35:0] t;
    logic [63:0] w;
    logic [7:0]  m;
    logic [3:0]  rd;
    logic        c;
    rf[15] = pc_addr + 32'h4;
    rf[15][0] = 1'b0;
    ew = 1'b1; ep = 1'b0; en = 1; rd = {1'b0, o[2:0]}; r = 32'h0; c = fl.c;
    d = rf[rd]; s = rf[{1'b0, o[5:3]}]; m = s[7:0]; t = {fl, 32'h0};
    if (o[15:11] == CAD_F2_TAG) begin
      // operand pick and add or subtract
      s = o[10] ? {29'h0, o[8:6]} : rf[{1'b0, o[8:6]}];
      d = rf[{1'b0, o[5:3]}];
      t = o[9] ? addc(d, ~s, 1'b1) : addc(d, s, 1'b0);
    end else if (o[15:13] == CAD_F3_TAG) begin
      rd = {1'b0, o[10:8]}; d = rf[rd]; s = {24'h0, o[7:0]};
      case (o[12:11])
        CAD_I8_MOV: t = {1'b0, s == 32'h0, fl.c, fl.v, s};
        CAD_I8_CMP: begin t = addc(d, ~s, 1'b1); ew = 1'b0; end
        CAD_I8_ADD: t = addc(d, s, 1'b0);
        default:    t = addc(d, ~s, 1'b1);
      endcase
    end else if (o[15:10] == CAD_F4_TAG) begin
      case (o[9:6])
        CAD_OP_ADC: t = addc(d, s, fl.c);
        CAD_OP_SUBC: t = addc(d, ~s, fl.c);
        CAD_OP_NEGATE: t = addc(32'h0, ~s, 1'b1);
        CAD_OP_CMP: t = addc(d, ~s, 1'b1);
        CAD_OP_CMPADD: t = addc(d, s, 1'b0);
        CAD_OP_AND, CAD_OP_ANDT: r = d & s;
        CAD_OP_XOR: r = d ^ s;
        CAD_OP_OR: r = d | s;
        CAD_OP_ANDN: r = d & ~s;
        CAD_OP_NOT: r = ~s;
        CAD_OP_MULT: begin r = d * s; en = mult_cycles(d); end
        CAD_OP_LSL: begin w = {32'h0, d} << m; r = w[31:0]; if (m != 0) c = w[32]; end
        CAD_OP_LSR: begin w = {d, 32'h0} >> m; r = w[63:32]; if (m != 0) c = w[31]; end
        CAD_OP_ASHR: begin w = $signed({d, 32'h0}) >>> m; r = w[63:32]; if (m != 0) c = w[31]; end
        default: begin r = (d >> m[4:0]) | (d << (6'd32 - m[4:0])); if (m != 0) c = r[31]; end
      endcase
      if (o[9:6] inside {[CAD_OP_LSL:CAD_OP_ASHR], CAD_OP_ROTR}) en = 2;
      if (!(o[9:6] inside {CAD_OP_ADC, CAD_OP_SUBC, CAD_OP_NEGATE, CAD_OP_CMP, CAD_OP_CMPADD}))
        t = {r[31], r == 32'h0, c, fl.v, r};
      if (o[9:6] inside {CAD_OP_ANDT, CAD_OP_CMP, CAD_OP_CMPADD}) ew = 1'b0;
    end else if (o[15:10] == CAD_F5_TAG) begin
      rd = {o[7], o[2:0]}; d = rf[rd]; s = rf[{o[6], o[5:3]}];
      r = (o[9:8] == CAD_HI_ADD) ? d + s : s;
      t = (o[9:8] == CAD_HI_CMP) ? addc(d, ~s, 1'b1) : {fl, r};
      if (o[9:8] == CAD_HI_CMP || o[9:8] == CAD_HI_BRX) ew = 1'b0;
      if (o[9:8] == CAD_HI_BRX) th = s[0];
      if (o[9:8] == CAD_HI_BRX || (ew && rd == CAD_PC_REG)) begin
        ep = 1'b1; ew = 1'b0; en = 3; pt = {r[31:1], 1'b0};
      end
    end else ew = 1'b0;
    fl = t[35:32]; ea = rd; ev = t[31:0];
    if (ew) rf[rd] = ev;
  endtask : exec

  // offer one opcode, wait for ready to return, compare everything
  task automatic run(input logic [15:0] o);
    int k;
    exec(o);
    cad_fetch_model_inst.send(o, pc_addr);
    @(negedge mclk);
    cad_fetch_model_inst.drop();
    for (k = 1; k < 9 && ready_ff !== 1'b1; k++) @(negedge mclk);
    `CHK(k, en)
    `CHK(wr_en_ff, ew)
    if (ew) `CHK({wr_addr_ff, wr_data_ff}, {ea, ev})
    `CHK({pc_load_ff, cstate_ff}, {ep, th})
    if (ep) `CHK(pc_tgt_ff, pt)
    `CHK(flags_ff, fl)
  endtask : run

  initial begin
    seed = 32'h27F8;
    pc_addr = 32'h0000_0200; th = CAD_RST_CSTATE; fl = '0;
    for (i = 0; i < 16; i++) rf[i] = 32'h0;
    repeat (10) @(negedge mclk);
    `CHK({ready_ff, wr_en_ff, pc_load_ff, cstate_ff, flags_ff}, {3'h4, th, fl})
    rst = 1'b0;
    $display("test reset done");
    // low registers, then high bank copies
    for (i = 0; i < 8; i++) run({CAD_F3_TAG, CAD_I8_MOV, i[2:0], 8'($random(seed))});
    for (i = 0; i < 7; i++) run({CAD_F5_TAG, CAD_HI_MOV, 2'b10, i[2:0], i[2:0]});
    $display("test fill done");
    // shift amounts 0, 32 and 33 on a negative value
    for (i = 0; i < 12; i++) begin
      run({CAD_F3_TAG, CAD_I8_MOV, 3'h1, (i % 3 == 0) ? 8'h00 : 8'h1F + 8'(i % 3)});
      run({CAD_F4_TAG, CAD_OP_NOT, 3'h7, 3'h2});
      run({CAD_F4_TAG, shk[i / 3], 3'h1, 3'h2});
    end
    // multiplier sizes give 2, 3 and 5 cycles
    run({CAD_F3_TAG, CAD_I8_MOV, 3'h0, 8'hFF});
    repeat (3) run({CAD_F4_TAG, CAD_OP_MULT, 3'h0, 3'h0});
    // branch from low and high register, both states
    for (i = 0; i < 2; i++) begin
      run({CAD_F3_TAG, CAD_I8_MOV, 3'h3, 7'h40, i[0]});
      run({CAD_F5_TAG, CAD_HI_MOV, 2'b10, 3'h3, 3'h1});
      run({CAD_F5_TAG, CAD_HI_BRX, 2'b00, 3'h3, 3'h0});
      run({CAD_F5_TAG, CAD_HI_BRX, 2'b01, 3'h1, 3'h0});
    end
    // pc write, pc read, then an opcode of no group
    run({CAD_F5_TAG, CAD_HI_MOV, 2'b10, 3'h5, 3'h7});
    run({CAD_F5_TAG, CAD_HI_MOV, 2'b01, 3'h7, 3'h4});
    run({CAD_F5_TAG, CAD_HI_MOV, 2'b11, 3'h7, 3'h2});
    run(16'hE000);
    // back to back: the add result feeds the next opcode
    op = {CAD_F3_TAG, CAD_I8_ADD, 3'h6, 8'h81};
    exec(op);
    cad_fetch_model_inst.send(op, pc_addr);
    run({CAD_F2_TAG, 2'b00, 3'h6, 3'h6, 3'h5});
    $display("test corners done");
    for (i = 0; i < 120; i++) begin
      op = 16'($random(seed));
      pc_addr = $random(seed);
      case (2'($random(seed)))
        2'h0: op[15:11] = CAD_F2_TAG;
        2'h1: op[15:13] = CAD_F3_TAG;
        2'h2: op[15:10] = CAD_F4_TAG;
        default: begin
          op[15:10] = CAD_F5_TAG;
          if (op[9:8] == CAD_HI_BRX) begin op[7] = 1'b0; op[3] = 1'b0; end
          else if (!op[7]) op[6] = 1'b1;
          if (op[9:8] != CAD_HI_CMP && op[7]) op[2] = 1'b0;
        end
      endcase
      run(op);
    end
    $display("test random done");
    results();
  end
endmodule : cad_decoder_bench
